// ==== dnr_pkg.sv ====
/*
  Package for the dialed number recorder: counter widths, positions,
  debounce timing and the carrier structs shared by the top and the
  contact conditioner.
  Assumes a single 200 MHz clock domain.
*/
package dnr_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned DEBOUNCE_US      = 5000;
  localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned DIGITS_DEFAULT   = 10;

  localparam int unsigned DIGIT_W          = 4;
  localparam logic [3:0]  POSITION_ZERO    = 4'h0;
  localparam logic [3:0]  POSITION_ONE     = 4'h1;
  localparam logic [3:0]  POSITION_LAST    = 4'h9;
  localparam logic [3:0]  DIGIT_STEP       = 4'h1;

  typedef struct packed {
    logic hook_switch;
    logic dial_off_stop_contact;
    logic dial_pulse_contact;
  } dnr_contacts_type;

  typedef struct packed {
    logic hook_lift;
    logic hook_drop;
    logic off_stop_open;
    logic pulse_open;
    logic off_hook;
  } dnr_events_type;

endpackage : dnr_pkg

// ==== dnr_contact_cond.sv ====
/*
  Contact conditioner: two-flop synchroniser and debounce filter for
  each mechanical contact, with edge events on the debounced levels.
  Assumes raw contacts are asynchronous and bounce for less than the
  debounce time.
*/
`timescale 1ns/1ps
module dnr_contact_cond #(
  parameter int unsigned DEBOUNCE_CYCLES = dnr_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire dnr_pkg::dnr_contacts_type contacts_raw,
  output dnr_pkg::dnr_events_type        events
);

  localparam int unsigned N   = 3;
  localparam int unsigned CW  = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(DEBOUNCE_CYCLES);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  // Reset to the idle contact levels so no false opening follows reset
  localparam dnr_pkg::dnr_contacts_type IDLE_LEVELS = '{
    hook_switch:           1'b0,
    dial_off_stop_contact: 1'b1,
    dial_pulse_contact:    1'b1
  };

  logic [N-1:0] raw;
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] stable_r;
  logic [N-1:0] stable_nxt;
  logic [N-1:0] prev_r;
  logic [N-1:0] rise;
  logic [N-1:0] fall;

  assign raw = contacts_raw;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= IDLE_LEVELS;
      sync_r <= IDLE_LEVELS;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  // A change must hold a full debounce time before it is accepted
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_deb
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;
      logic          stab_n;
      // One driver per bit: the shared vector is fed by assign
      assign stable_nxt[g] = stab_n;
      always_comb begin
        cnt_nxt = '0;
        stab_n  = stable_r[g];
        if (sync_r[g] != stable_r[g]) begin
          if (cnt_r == CNT_MAX) begin
            stab_n = sync_r[g];
          end else begin
            cnt_nxt = cnt_r + CNT_ONE;
          end
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_r <= IDLE_LEVELS;
      prev_r   <= IDLE_LEVELS;
    end else begin
      stable_r <= stable_nxt;
      prev_r   <= stable_r;
    end
  end

  assign rise = stable_r & ~prev_r;
  assign fall = ~stable_r & prev_r;

  // Bit order follows the struct: hook, off-stop, pulse
  always_comb begin
    events.off_hook      = stable_r[2];
    events.hook_lift     = rise[2];
    events.hook_drop     = fall[2];
    events.off_stop_open = fall[1];
    events.pulse_open    = fall[0];
  end

endmodule : dnr_contact_cond

// ==== dnr_recorder.sv ====
/*
  Dialed number recorder top: a selector counter steps once per dialed
  digit and enables one decade recorder at a time, which counts the
  dial interruptions of that digit.
  Assumes hook_switch high means handset lifted, dial contacts high
  when closed; all contacts raw and asynchronous.
*/
`timescale 1ns/1ps
module dnr_recorder #(
  parameter int unsigned DIGITS          = dnr_pkg::DIGITS_DEFAULT,
  parameter int unsigned DEBOUNCE_CYCLES = dnr_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          hook_switch,
  input  wire logic                          dial_off_stop_contact,
  input  wire logic                          dial_pulse_contact,
  output logic                               recorders_powered,
  output logic [dnr_pkg::DIGIT_W-1:0]        selector_position,
  output logic [DIGITS*dnr_pkg::DIGIT_W-1:0] digits,
  output logic [DIGITS-1:0]                  digit_visible,
  output logic [DIGITS-1:0]                  digit_enabled
);

  localparam int unsigned W = dnr_pkg::DIGIT_W;

  typedef enum logic [0:0] {
    DNR_ON_HOOK,
    DNR_OFF_HOOK
  } dnr_state_type;

  dnr_pkg::dnr_contacts_type contacts;
  dnr_pkg::dnr_events_type   ev;

  // Hook state and the lift clear
  dnr_state_type       state_r;
  dnr_state_type       state_nxt;
  logic                clr_armed_r;
  logic                clr_armed_nxt;

  // Selector
  logic [W-1:0]        sel_r;
  logic [W-1:0]        sel_nxt;
  logic                sel_clear;
  logic                sel_step;

  // Recorder vectors, one slice per digit
  logic [DIGITS-1:0]   vis_r;
  logic [DIGITS-1:0]   vis_nxt;
  logic [DIGITS-1:0]   en_r;
  logic [DIGITS-1:0]   en_nxt;
  logic [DIGITS*W-1:0] dig_r;
  logic [DIGITS*W-1:0] dig_nxt;

  always_comb begin
    contacts.hook_switch           = hook_switch;
    contacts.dial_off_stop_contact = dial_off_stop_contact;
    contacts.dial_pulse_contact    = dial_pulse_contact;
  end

  // Debounce length is a parameter so a bench can shorten it
  dnr_contact_cond #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_cond (
    .clk          (clk),
    .rst          (rst),
    .contacts_raw (contacts),
    .events       (ev)
  );

  // Hook state and the one-shot selector clear
  always_comb begin
    state_nxt     = state_r;
    clr_armed_nxt = clr_armed_r;
    sel_clear     = 1'b0;
    case (state_r)
      DNR_ON_HOOK: begin
        if (ev.hook_lift) begin
          state_nxt     = DNR_OFF_HOOK;
          sel_clear     = clr_armed_r;
          clr_armed_nxt = 1'b0;
        end
      end
      DNR_OFF_HOOK: begin
        if (ev.hook_drop) begin
          state_nxt     = DNR_ON_HOOK;
          clr_armed_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = DNR_ON_HOOK;
      end
    endcase
  end

  // Re-arm starts set so the first lift after reset clears too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= DNR_ON_HOOK;
      clr_armed_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      clr_armed_r <= clr_armed_nxt;
    end
  end

  // Selector: modulo ten, zero means no digit selected yet
  // Dial events count only off hook; on-hook dialling is refused
  assign sel_step = state_r == DNR_OFF_HOOK && ev.off_stop_open;

  always_comb begin
    sel_nxt = sel_r;
    if (sel_clear) begin
      sel_nxt = dnr_pkg::POSITION_ZERO;
    end else if (sel_step) begin
      if (sel_r == dnr_pkg::POSITION_LAST) begin
        // Wrap leaves every recorder deselected until position one
        sel_nxt = dnr_pkg::POSITION_ZERO;
      end else begin
        sel_nxt = sel_r + dnr_pkg::DIGIT_STEP;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_r <= dnr_pkg::POSITION_ZERO;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // Recorder i is selected at position i+1; beyond DIGITS none is
  genvar i;
  generate
    for (i = 0; i < DIGITS; i++) begin : g_rec
      localparam logic [W-1:0] MY_POS = W'(i + 1);

      logic         clear_all;
      logic         step_in;
      logic         step_away;
      logic         pulse_in;
      logic [W-1:0] cur;
      logic         en_n;
      logic         vis_n;
      logic [W-1:0] dig_n;

      // In the recorders, hook drop wins over any dial event in the same cycle
      assign clear_all = state_r == DNR_ON_HOOK || ev.hook_drop;
      assign step_in   = sel_step && sel_nxt == MY_POS;
      assign step_away = sel_step && !step_in;
      assign pulse_in  = en_r[i] && ev.pulse_open;
      assign cur       = dig_r[i*W +: W];

      always_comb begin
        en_n  = en_r[i];
        vis_n = vis_r[i];
        dig_n = cur;
        if (clear_all) begin
          en_n  = 1'b0;
          vis_n = 1'b0;
          dig_n = dnr_pkg::POSITION_ZERO;
        end else if (step_in) begin
          en_n  = 1'b1;
          vis_n = 1'b1;
          dig_n = dnr_pkg::POSITION_ZERO;
        end else begin
          // Step away disables; pulses only reach the enabled one
          if (step_away) begin
            en_n = 1'b0;
          end
          if (pulse_in) begin
            if (cur == dnr_pkg::POSITION_LAST) begin
              dig_n = dnr_pkg::POSITION_ZERO;
            end else begin
              dig_n = cur + dnr_pkg::DIGIT_STEP;
            end
          end
        end
      end

      // One driver per slice of the shared next-state vectors
      assign en_nxt[i]         = en_n;
      assign vis_nxt[i]        = vis_n;
      assign dig_nxt[i*W +: W] = dig_n;
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r  <= '0;
      vis_r <= '0;
      dig_r <= '0;
    end else begin
      en_r  <= en_nxt;
      vis_r <= vis_nxt;
      dig_r <= dig_nxt;
    end
  end

  // Data outputs come straight from registers
  assign recorders_powered = state_r == DNR_OFF_HOOK;
  assign selector_position = sel_r;
  assign digits            = dig_r;
  assign digit_visible     = vis_r;
  assign digit_enabled     = en_r;

endmodule : dnr_recorder

// ==== dnr_recorder_chk.sv ====
/*
  Checker for the recorder top, seeing its ports only.
  Assumes the bind below and one clock domain with async reset.
*/
`timescale 1ns/1ps
module dnr_recorder_chk #(
  parameter int unsigned DIGITS = 10
) (
  input wire logic                            clk,
  input wire logic                            rst,
  input wire logic                            hook_switch,
  input wire logic                            dial_off_stop_contact,
  input wire logic                            dial_pulse_contact,
  input wire logic                            recorders_powered,
  input wire logic [dnr_pkg::DIGIT_W-1:0]        selector_position,
  input wire logic [DIGITS*dnr_pkg::DIGIT_W-1:0] digits,
  input wire logic [DIGITS-1:0]                  digit_visible,
  input wire logic [DIGITS-1:0]                  digit_enabled
);
  logic [DIGITS-1:0] en_exp;
  always_comb begin
    en_exp = '0;
    if (selector_position >= 4'h1 && selector_position <= DIGITS) begin
      en_exp[selector_position - 4'h1] = 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_step;
    recorders_powered ##1 (recorders_powered && $changed(selector_position));
  endsequence
  sequence s_cnt;
    recorders_powered ##1 (recorders_powered && $changed(digits[3:0]));
  endsequence
  property p_idle;
    !recorders_powered |-> digits == '0 && digit_enabled == '0 && digit_visible == '0;
  endproperty
  property p_hold;
    !recorders_powered && !$past(recorders_powered) |-> $stable(selector_position);
  endproperty
  property p_lift;
    $rose(recorders_powered) |-> selector_position == 4'h0 && digit_visible == '0;
  endproperty
  property p_step;
    s_step |-> selector_position == (($past(selector_position) == 4'h9) ? 4'h0 : $past(selector_position) + 4'h1);
  endproperty
  property p_en;
    recorders_powered |-> digit_enabled == en_exp;
  endproperty
  property p_clr;
    $rose(digit_enabled[0]) |-> digits[3:0] == 4'h0;
  endproperty
  property p_cnt;
    s_cnt |-> digit_enabled[0] && (digits[3:0] == 4'h0 || digits[3:0] == $past(digits[3:0]) + 4'h1);
  endproperty
  property p_vis;
    $rose(digit_visible[0]) |-> selector_position == 4'h1 && digits[3:0] == 4'h0;
  endproperty
  property p_mod;
    recorders_powered |-> selector_position <= 4'h9 && digits[3:0] <= 4'h9;
  endproperty
  property p_deb;
    s_step |-> !$past(dial_off_stop_contact, 2) && !$past(dial_off_stop_contact, 6);
  endproperty
  property p_pw;
    $rose(recorders_powered) |-> $past(hook_switch, 2) && $past(hook_switch, 6);
  endproperty
  a_idle: assert property (p_idle) else $error("idle outputs not cleared");
  a_hold: assert property (p_hold) else $error("selector moved on hook");
  a_lift: assert property (p_lift) else $error("selector not zero on lift");
  a_step: assert property (p_step) else $error("selector step wrong");
  a_en: assert property (p_en) else $error("wrong recorder enabled");
  a_clr: assert property (p_clr) else $error("recorder not cleared on select");
  a_cnt: assert property (p_cnt) else $error("recorder count wrong");
  a_vis: assert property (p_vis) else $error("display shown too early");
  a_mod: assert property (p_mod) else $error("count beyond nine");
  a_deb: assert property (p_deb) else $error("step without stable opening");
  a_pw: assert property (p_pw) else $error("power without stable lift");
endmodule : dnr_recorder_chk

bind dnr_recorder dnr_recorder_chk #(.DIGITS(DIGITS)) u_chk (
  .clk(clk), .rst(rst), .hook_switch(hook_switch), .dial_off_stop_contact(dial_off_stop_contact),
  .dial_pulse_contact(dial_pulse_contact), .recorders_powered(recorders_powered),
  .selector_position(selector_position), .digits(digits), .digit_visible(digit_visible),
  .digit_enabled(digit_enabled));

// ==== dnr_phone_model.sv ====
/*
  Phone model: hook switch and rotary dial contacts, with bounce.
  Assumes the bench calls its tasks and gives the 200 MHz clock.
*/
`timescale 1ns/1ps
module dnr_phone_model (
  input  wire logic               clk,
  output dnr_pkg::dnr_contacts_type c
);
  localparam int HOLD = 14;
  initial c = 3'b011;
  // One-cycle bounce first; the debounce has to swallow it
  task automatic move(input int b, input logic v);
    @(posedge clk) #1 c[b] = v;
    @(posedge clk) #1 c[b] = !v;
    @(posedge clk) #1 c[b] = v;
    repeat (HOLD) @(posedge clk);
  endtask : move
  task automatic dial(input int n);
    move(1, 1'b0);
    repeat (n) begin
      move(0, 1'b0);
      move(0, 1'b1);
    end
    move(1, 1'b1);
  endtask : dial
endmodule : dnr_phone_model

// ==== test_dialed_number_recorder.sv ====
/*
  Bench for the recorder top against an integer model.
  Assumes the phone model drives the contacts.
*/
`timescale 1ns/1ps
module test_dialed_number_recorder;
  localparam int DG = 3;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  dnr_pkg::dnr_contacts_type con;
  logic                      pw;
  logic [3:0]                sel;
  logic [DG*4-1:0]           dg;
  logic [DG-1:0]             vis;
  logic [DG-1:0]             en;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int m_pw, m_sel, m_vis;
  int m_dg[DG];
  dnr_phone_model ph (.clk(clk), .c(con));
  dnr_recorder #(.DIGITS(DG), .DEBOUNCE_CYCLES(4)) dut (.clk(clk), .rst(rst), .hook_switch(con.hook_switch),
    .dial_off_stop_contact(con.dial_off_stop_contact), .dial_pulse_contact(con.dial_pulse_contact),
    .recorders_powered(pw), .selector_position(sel), .digits(dg), .digit_visible(vis), .digit_enabled(en));
  initial forever #2.5 clk = !clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic look();
    int i;
    chk("powered", m_pw, {31'h0, pw});
    chk("selector", m_sel, {28'h0, sel});
    chk("visible", m_vis, {29'h0, vis});
    chk("enabled", (m_pw != 0 && m_sel >= 1 && m_sel <= DG) ? 1 << (m_sel - 1) : 0, {29'h0, en});
    for (i = 0; i < DG; i++) chk("digit", m_dg[i], {28'h0, dg[i*4 +: 4]});
  endtask : look
  task automatic do_dial(input int n);
    ph.dial(n);
    if (m_pw != 0) begin
      m_sel = (m_sel + 1) % 10;
      if (m_sel >= 1 && m_sel <= DG) begin
        m_dg[m_sel-1] = n % 10;
        m_vis |= 1 << (m_sel - 1);
      end
    end
    look();
  endtask : do_dial
  task automatic hook(input logic v);
    ph.move(2, v);
    m_pw = v;
    // Selector keeps its place on hook until the next lift clears it
    if (v) begin
      m_sel = 0;
    end else begin
      m_vis = 0;
      foreach (m_dg[i]) m_dg[i] = 0;
    end
    look();
  endtask : hook
  initial begin
    int k;
    void'($urandom(32'hcd97));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    look();
    do_dial(2);
    hook(1'b1);
    // Twelve digits: selector wraps and recorder one is reselected
    for (k = 0; k < 12; k++) do_dial(k == 0 ? 10 : $urandom % 4);
    hook(1'b0);
    hook(1'b1);
    do_dial(1 + $urandom % 9);
    close_out();
  end
endmodule : test_dialed_number_recorder
